/* File: rtl/sysctl_consts.svh */
// Constants for the reset, watchdog and interrupt entry controller.
// Assumes inclusion by bare name from the package and the main module.
`ifndef SYSCTL_CONSTS_SVH
`define SYSCTL_CONSTS_SVH

// ==========================================================
// Register offsets on the APB (byte addresses).
`define ADDR_RSTSTAT 8'h00
`define ADDR_SYSOPT 8'h04
`define ADDR_IRQFLAG 8'h08
`define ADDR_IRQEN 8'h0C

// ==========================================================
// Field positions and reset values.
`define STAT_POR 7
`define STAT_PIN 6
`define STAT_WDOG 5
`define STAT_ILOP 4
`define STAT_LOC 2
`define STAT_LOWV 1
`define OPT_EN 7
`define OPT_SEL 6
`define OPT_RESET 8'hC0
`define COND_I 3
`define SP_RESET 16'h00FF
`define VEC_RESET 16'hFFFE
`define VEC_IRQ_BASE 16'hFFE0
`define NUM_IRQ 8
`define QUEUE_FILL 3

// ==========================================================
// Timing counts in bus cycles.
`define RST_DRIVE_CYC 34
`define RST_WAIT_CYC 38
`define WD_LONG_CYC 262144
`define WD_SHORT_CYC 8192

`endif

/* File: rtl/sysctl_pkg.sv */
// Types shared by the controller and its testbench.
// Assumes the constants header is on the include path.
`include "sysctl_consts.svh"
package sysctl_pkg;

   // ==========================================================
   // CPU context handed over at entry and return.
   typedef struct packed
   {
      logic [15:0] pc;
      logic [15:0] sp;
      logic [7:0] a;
      logic [7:0] x;
      logic [7:0] cond;
   } cpuRegs_t;

   // One memory access request per cycle.
   typedef struct packed
   {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic rd;
      logic wr;
   } memReq_t;

   // Reset pin phases; 2'b10 is illegal.
   typedef enum logic [1:0]
   {
      RP_RUN = 2'h0,
      RP_DRIVE = 2'h1,
      RP_WAIT = 2'h3
   } rstPhase_t;

   // Sequencer states, Gray coded along the entry path.
   typedef enum logic [3:0]
   {
      SQ_IDLE = 4'h0, SQ_PCLO = 4'h1, SQ_PCH = 4'h3, SQ_X = 4'h2,
      SQ_A = 4'h6, SQ_COND = 4'h7, SQ_VHI = 4'h5, SQ_VLO = 4'h4,
      SQ_FILL = 4'hC, SQ_RCCR = 4'hD, SQ_RA = 4'hF, SQ_RX = 4'hE,
      SQ_RPCH = 4'hA, SQ_RPCL = 4'hB, SQ_RSTHI = 4'h9,
      SQ_RSTLO = 4'h8
   } seqState_t;

endpackage

/* File: rtl/wdog_counter.sv */
// Free running watchdog counter with terminal detect.
// Assumes one tick per bus clock and a synchronous clear.
`timescale 1ns/100ps
module wdog_counter
#(
   parameter int W = 18
)
(
   input wire logic clk,
   input wire logic clr,
   input wire logic run,
   input wire logic [W-1:0] last,
   output logic [W-1:0] count,
   output logic trip
);

   // ==========================================================
   // Counter.
   // Terminal count is reached when the selected period ends.
   assign trip = run && (count == last);

   // Counts while running, restarts from zero on clear or trip.
   // per-cycle count
   always_ff @(posedge clk)
   begin
      if (clr || trip)
      begin
         count <= '0;
      end
      else if (run)
      begin
         count <= count + W'(1);
      end
   end

endmodule

/* File: rtl/sys_reset_irq_ctrl.sv */
// Reset sequencing, watchdog and interrupt entry/return control.
// Assumes clk is the bus clock, inputs synchronous, APB master.
`timescale 1ns/100ps
`include "sysctl_consts.svh"
module sys_reset_irq_ctrl
#(
   parameter int WD_LONG_CYCLES = `WD_LONG_CYC,
   parameter int WD_SHORT_CYCLES = `WD_SHORT_CYC
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lowvReset,
   input wire logic ilopReset,
   input wire logic locReset,
   input wire logic bdmReset,
   input wire logic bdmActive,
   input wire logic resetPinIn,
   output logic resetPinOut,
   output logic resetPinOe,
   output logic inReset,
   output logic periphDisable,
   output logic ioForceInput,
   output logic clkGenSelfClock,
   input wire logic [7:0] irqEvent,
   input wire logic instrDone,
   input wire logic retExec,
   input wire sysctl_pkg::cpuRegs_t cpuRegsIn,
   output sysctl_pkg::cpuRegs_t regsOut,
   output logic regLoad,
   output sysctl_pkg::memReq_t memReq,
   input wire logic [7:0] memRdData,
   output logic seqBusy
);
   import sysctl_pkg::*;

   // ==========================================================
   // Declarations.
   localparam logic [17:0] WD_LONG_LAST = 18'(WD_LONG_CYCLES - 1);
   localparam logic [17:0] WD_SHORT_LAST = 18'(WD_SHORT_CYCLES - 1);
   rstPhase_t rstPhase; // Reset pin phase.
   logic [5:0] rstCnt; // Bus cycles within a phase.
   logic [7:0] causeLatch; // Causes of the reset in progress.
   logic [7:0] rstat; // Reset source status.
   logic [7:0] opts; // System options.
   logic optLocked; // Options written since reset.
   logic [7:0] irqFlag; // Sticky source flags.
   logic [7:0] irqEn; // Local enables.
   logic [7:0] irqPend; // Flagged and enabled.
   logic irqReq; // Any qualified source.
   logic iMask; // Global mask of the running CPU.
   logic [2:0] prioIdx; // Highest pending source.
   logic [2:0] vecIdx; // Source being entered.
   logic [15:0] vecAddr; // Vector high byte address.
   seqState_t seq; // Sequencer state.
   cpuRegs_t ctx; // Working copy of CPU context.
   logic [1:0] fillCnt; // Queue bytes fetched.
   logic [17:0] wdCount; // Watchdog count.
   logic wdTrip; // Watchdog timeout.
   logic wdRun; // Watchdog counting.
   logic extLow; // Pin pulled low from outside.
   logic anyCause; // Any reset request.
   logic apbWr; // APB write access phase.
   logic svcWr; // Service write.
   logic optWr; // Options write.
   logic mapped; // Address decodes.

   // ==========================================================
   // APB slave.
   // Zero wait states; unmapped addresses answer with an error.
   assign apbWr = psel && penable && pwrite;
   assign mapped = (paddr == `ADDR_RSTSTAT) || (paddr == `ADDR_SYSOPT)
      || (paddr == `ADDR_IRQFLAG) || (paddr == `ADDR_IRQEN);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign svcWr = apbWr && (paddr == `ADDR_RSTSTAT);
   assign optWr = apbWr && (paddr == `ADDR_SYSOPT);

   // Read data is captured in the setup cycle.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (psel && !penable)
      begin
         unique case (paddr)
            `ADDR_RSTSTAT: prdata <= {24'h00_0000, rstat};
            `ADDR_SYSOPT: prdata <= {24'h00_0000, opts};
            `ADDR_IRQFLAG: prdata <= {24'h00_0000, irqFlag};
            `ADDR_IRQEN: prdata <= {24'h00_0000, irqEn};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Reset pin sequence.
   assign extLow = !resetPinIn && (rstPhase == RP_RUN);
   assign anyCause = wdTrip || lowvReset || ilopReset || locReset
      || bdmReset || extLow;
   assign inReset = (rstPhase != RP_RUN);
   assign periphDisable = inReset;
   assign ioForceInput = inReset;
   assign clkGenSelfClock = inReset;
   assign resetPinOe = (rstPhase == RP_DRIVE);
   assign resetPinOut = 1'b0;

   // Walks drive and wait phases; holds while the pin stays low.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rstPhase <= RP_DRIVE;
         rstCnt <= 6'h00;
         causeLatch <= 8'h80;
      end
      else
      begin
         unique case (rstPhase)
            RP_RUN:
            begin
               if (anyCause)
               begin
                  rstPhase <= RP_DRIVE;
                  rstCnt <= 6'h00;
                  causeLatch <= '0;
                  causeLatch[`STAT_WDOG] <= wdTrip;
                  causeLatch[`STAT_LOWV] <= lowvReset;
                  causeLatch[`STAT_ILOP] <= ilopReset;
                  causeLatch[`STAT_LOC] <= locReset;
                  // A short external pulse is gone by the sample point.
                  causeLatch[`STAT_PIN] <= extLow;
               end
            end
            RP_DRIVE:
            begin
               if (rstCnt == 6'(`RST_DRIVE_CYC - 1))
               begin
                  rstPhase <= RP_WAIT;
                  rstCnt <= 6'h00;
               end
               else
               begin
                  rstCnt <= rstCnt + 6'h01;
               end
            end
            RP_WAIT:
            begin
               if (rstCnt != 6'(`RST_WAIT_CYC - 1))
               begin
                  rstCnt <= rstCnt + 6'h01;
               end
               else if (resetPinIn)
               begin
                  rstPhase <= RP_RUN;
               end
               else
               begin
                  // Pin held low from outside at the sample point.
                  causeLatch[`STAT_PIN] <= 1'b1;
               end
            end
            default:
            begin
               rstPhase <= RP_DRIVE;
               rstCnt <= 6'h00;
            end
         endcase
      end
   end

   // Status is written once the pin has been sampled.
   // cause recording
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rstat <= 8'h00;
      end
      else if (rstPhase == RP_WAIT
         && rstCnt == 6'(`RST_WAIT_CYC - 1))
      begin
         // The pin flag survives the final write made with the pin high.
         rstat <= causeLatch;
         rstat[`STAT_PIN] <= causeLatch[`STAT_PIN] || !resetPinIn;
      end
   end

   // ==========================================================
   // Watchdog and options.
   // Options return to defaults on every reset and lock on write.
   always_ff @(posedge clk)
   begin
      if (srst || inReset)
      begin
         opts <= `OPT_RESET;
         optLocked <= 1'b0;
      end
      else if (optWr && !optLocked)
      begin
         opts <= pwdata[7:0] & `OPT_RESET;
         optLocked <= 1'b1;
      end
   end

   assign wdRun = opts[`OPT_EN] && !inReset && !bdmActive;

   wdog_counter #(.W(18)) u_wdog
   (
      .clk(clk),
      .clr(srst || inReset || svcWr),
      .run(wdRun),
      .last(opts[`OPT_SEL] ? WD_LONG_LAST : WD_SHORT_LAST),
      .count(wdCount),
      .trip(wdTrip)
   );

   // ==========================================================
   // Interrupt sources.
   // A new event wins over a clear in the same cycle.
   // sticky flags
   always_ff @(posedge clk)
   begin
      if (srst || inReset)
      begin
         irqFlag <= 8'h00;
      end
      else if (apbWr && paddr == `ADDR_IRQFLAG)
      begin
         irqFlag <= (irqFlag & ~pwdata[7:0]) | irqEvent;
      end
      else
      begin
         irqFlag <= irqFlag | irqEvent;
      end
   end

   // Local enables are plain read/write bits.
   always_ff @(posedge clk)
   begin
      if (srst || inReset)
      begin
         irqEn <= 8'h00;
      end
      else if (apbWr && paddr == `ADDR_IRQEN)
      begin
         irqEn <= pwdata[7:0];
      end
   end

   assign irqPend = irqFlag & irqEn;
   assign irqReq = |irqPend;
   assign iMask = cpuRegsIn.cond[`COND_I];
   assign vecAddr = 16'(`VEC_IRQ_BASE + {vecIdx, 1'b0});

   // Picks the highest index pending source.
   // priority pick
   always_comb
   begin
      prioIdx = 3'h0;
      for (int i = 0; i < `NUM_IRQ; i++)
      begin
         if (irqPend[i])
         begin
            prioIdx = 3'(i);
         end
      end
   end

   // ==========================================================
   // Entry, return and reset vector sequencer.
   assign regsOut = ctx;
   assign regLoad = (seq == SQ_FILL) && (fillCnt == 2'(`QUEUE_FILL - 1));
   assign seqBusy = inReset || (seq != SQ_IDLE);

   // At most one memory access per cycle; pops pre-increment SP.
   // no index high byte
   always_ff @(posedge clk)
   begin
      if (srst || inReset)
      begin
         seq <= SQ_RSTHI;
         ctx <= '0;
         ctx.sp <= `SP_RESET;
         ctx.cond[`COND_I] <= 1'b1;
         fillCnt <= 2'h0;
         vecIdx <= 3'h0;
      end
      else
      begin
         unique case (seq)
            SQ_IDLE:
            begin
               if (instrDone && irqReq && !iMask)
               begin
                  ctx <= cpuRegsIn;
                  vecIdx <= prioIdx;
                  seq <= SQ_PCLO;
               end
               else if (retExec)
               begin
                  ctx <= cpuRegsIn;
                  seq <= SQ_RCCR;
               end
            end
            SQ_PCLO:
            begin
               ctx.sp <= ctx.sp - 16'h0001;
               seq <= SQ_PCH;
            end
            SQ_PCH:
            begin
               ctx.sp <= ctx.sp - 16'h0001;
               seq <= SQ_X;
            end
            SQ_X:
            begin
               ctx.sp <= ctx.sp - 16'h0001;
               seq <= SQ_A;
            end
            SQ_A:
            begin
               ctx.sp <= ctx.sp - 16'h0001;
               seq <= SQ_COND;
            end
            SQ_COND:
            begin
               ctx.sp <= ctx.sp - 16'h0001;
               ctx.cond[`COND_I] <= 1'b1;
               seq <= SQ_VHI;
            end
            SQ_VHI:
            begin
               ctx.pc[15:8] <= memRdData;
               seq <= SQ_VLO;
            end
            SQ_VLO:
            begin
               ctx.pc[7:0] <= memRdData;
               fillCnt <= 2'h0;
               seq <= SQ_FILL;
            end
            SQ_FILL:
            begin
               if (regLoad)
               begin
                  seq <= SQ_IDLE;
               end
               else
               begin
                  fillCnt <= fillCnt + 2'h1;
               end
            end
            SQ_RCCR:
            begin
               ctx.sp <= ctx.sp + 16'h0001;
               ctx.cond <= memRdData;
               seq <= SQ_RA;
            end
            SQ_RA:
            begin
               ctx.sp <= ctx.sp + 16'h0001;
               ctx.a <= memRdData;
               seq <= SQ_RX;
            end
            SQ_RX:
            begin
               ctx.sp <= ctx.sp + 16'h0001;
               ctx.x <= memRdData;
               seq <= SQ_RPCH;
            end
            SQ_RPCH:
            begin
               ctx.sp <= ctx.sp + 16'h0001;
               ctx.pc[15:8] <= memRdData;
               seq <= SQ_RPCL;
            end
            SQ_RPCL:
            begin
               ctx.sp <= ctx.sp + 16'h0001;
               ctx.pc[7:0] <= memRdData;
               fillCnt <= 2'h0;
               seq <= SQ_FILL;
            end
            SQ_RSTHI:
            begin
               ctx.pc[15:8] <= memRdData;
               seq <= SQ_RSTLO;
            end
            SQ_RSTLO:
            begin
               ctx.pc[7:0] <= memRdData;
               fillCnt <= 2'h0;
               seq <= SQ_FILL;
            end
         endcase
      end
   end

   // Drives the memory request of the current state.
   always_comb
   begin
      memReq = '0;
      if (!inReset)
      begin
         unique case (seq)
            SQ_IDLE: memReq = '0;
            SQ_PCLO: memReq = '{ctx.sp, ctx.pc[7:0], 1'b0, 1'b1};
            SQ_PCH: memReq = '{ctx.sp, ctx.pc[15:8], 1'b0, 1'b1};
            SQ_X: memReq = '{ctx.sp, ctx.x, 1'b0, 1'b1};
            SQ_A: memReq = '{ctx.sp, ctx.a, 1'b0, 1'b1};
            SQ_COND: memReq = '{ctx.sp, ctx.cond, 1'b0, 1'b1};
            SQ_VHI: memReq = '{vecAddr, 8'h00, 1'b1, 1'b0};
            SQ_VLO: memReq = '{vecAddr + 16'h0001, 8'h00, 1'b1, 1'b0};
            SQ_FILL: memReq = '{ctx.pc + 16'(fillCnt), 8'h00, 1'b1, 1'b0};
            SQ_RCCR, SQ_RA, SQ_RX, SQ_RPCH, SQ_RPCL:
               memReq = '{ctx.sp + 16'h0001, 8'h00, 1'b1, 1'b0};
            SQ_RSTHI: memReq = '{`VEC_RESET, 8'h00, 1'b1, 1'b0};
            SQ_RSTLO: memReq = '{`VEC_RESET + 16'h0001, 8'h00, 1'b1, 1'b0};
         endcase
      end
   end

   // ==========================================================
   // Assertions.
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_pin_drive;
      (rstPhase == RP_DRIVE && rstCnt == 6'd33) |=> !resetPinOe;
   endproperty
   a_pin_drive: assert property (p_pin_drive)
      else $error("reset pin drive length wrong");

   property p_pin_wait;
      $fell(resetPinOe) |-> (rstPhase == RP_WAIT)[*8];
   endproperty
   a_pin_wait: assert property (p_pin_wait)
      else $error("reset released too early");

   property p_rst_vec;
      (seq == SQ_RSTHI && !inReset) |-> memReq.rd
         && memReq.addr == 16'hFFFE;
   endproperty
   a_rst_vec: assert property (p_rst_vec)
      else $error("reset vector address wrong");

   property p_rst_ctx;
      (seq == SQ_RSTLO && !inReset) |-> ##3 (regLoad
         && regsOut.sp == 16'h00FF && regsOut.cond[3]);
   endproperty
   a_rst_ctx: assert property (p_rst_ctx)
      else $error("reset context not loaded");

   property p_service;
      (svcWr && rstPhase == RP_RUN && !anyCause) |=>
         wdCount == 18'h0_0000 && $stable(rstat);
   endproperty
   a_service: assert property (p_service)
      else $error("service write misbehaved");

   property p_bdm_hold;
      (bdmActive && !inReset) |=> $stable(wdCount) && !wdTrip;
   endproperty
   a_bdm_hold: assert property (p_bdm_hold)
      else $error("watchdog ran in debug mode");

   property p_stack_frame;
      (seq == SQ_PCLO) |-> ##5 (seq == SQ_VHI
         && ctx.sp == $past(ctx.sp, 5) - 16'h0005);
   endproperty
   a_stack_frame: assert property (p_stack_frame)
      else $error("stack frame size wrong");

   property p_mask_set;
      (seq == SQ_COND) |-> memReq.wr ##1 ctx.cond[3];
   endproperty
   a_mask_set: assert property (p_mask_set)
      else $error("mask not set on entry");

   property p_qualified;
      (seq == SQ_IDLE ##1 seq == SQ_PCLO) |->
         $past(irqReq) && !$past(iMask) && $past(instrDone);
   endproperty
   a_qualified: assert property (p_qualified)
      else $error("unqualified interrupt entry");

   property p_highest;
      (seq == SQ_IDLE ##1 seq == SQ_PCLO) |->
         ($past(irqPend) >> vecIdx) == 8'h01;
   endproperty
   a_highest: assert property (p_highest)
      else $error("lower priority source chosen");

endmodule

/* File: tb/sys_partner.sv */
// Far side model: CPU memory space and the board reset circuit.
// Assumes memory answers in the same cycle as the request.
`timescale 1ns/100ps
module sys_partner
(
   input wire logic clk,
   input wire sysctl_pkg::memReq_t memReq,
   output logic [7:0] memRdData,
   input wire logic resetPinOe,
   input wire logic resetPinOut,
   input wire logic extLow,
   output logic resetPinIn
);
   import sysctl_pkg::*;
   // Whole address space as bytes.
   logic [7:0] mem [0:65535];
   // ==========================================================
   // Vector table: boot at 16'h1234, source i at {8'h80, i}.
   initial
   begin
      mem[16'hFFFE] = 8'h12;
      mem[16'hFFFF] = 8'h34;
      for (int i = 0; i < 8; i++)
      begin
         mem[16'hFFE0 + 2 * i] = 8'h80;
         mem[16'hFFE1 + 2 * i] = i[7:0];
      end
   end
   // Stack writes land at the edge that closes the cycle.
   always @(posedge clk)
   begin
      if (memReq.wr)
      begin
         mem[memReq.addr] <= memReq.wdata;
      end
   end
   // An idle bus shows the inverse, so stale data never matches.
   assign memRdData = memReq.rd ? mem[memReq.addr] : ~mem[memReq.addr];
   // The pin rests on its pullup unless someone pulls it low.
   assign resetPinIn = !((resetPinOe && !resetPinOut) || extLow);
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the reset, watchdog and interrupt controller.
// Assumes small watchdog periods of 64 and 16 cycles.
`timescale 1ns/100ps
module tb_top;
   import sysctl_pkg::*;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic bdmActive = 0, instrDone = 0, retExec = 0, err;
   logic [7:0] paddr = 0, irqEvent = 0, memRdData, bits, top;
   logic [31:0] pwdata = 0, prdata, rdat, seed = 32'h0461;
   logic pready, pslverr, resetPinIn, resetPinOut, resetPinOe, inReset;
   logic periphDisable, ioForceInput, clkGenSelfClock, regLoad, seqBusy;
   logic [4:0] cause = 0; // Order: low voltage, ilop, loc, debug, pin.
   logic [7:0] statTab [5] = '{8'h02, 8'h10, 8'h04, 8'h00, 8'h40};
   cpuRegs_t cpuRegsIn = '0, regsOut, sv;
   memReq_t memReq;
   int fail_count = 0, checks = 0, cyc = 0, n;
   cpuRegs_t regQ[$], mskQ[$]; // Expected loads and compare masks.
   memReq_t wrQ[$]; // Expected stack writes.
   sys_reset_irq_ctrl #(.WD_LONG_CYCLES(64), .WD_SHORT_CYCLES(16)) i_dut
   (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lowvReset(cause[4]),
      .ilopReset(cause[3]), .locReset(cause[2]), .bdmReset(cause[1]),
      .bdmActive(bdmActive), .resetPinIn(resetPinIn),
      .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
      .inReset(inReset), .periphDisable(periphDisable),
      .ioForceInput(ioForceInput), .clkGenSelfClock(clkGenSelfClock),
      .irqEvent(irqEvent), .instrDone(instrDone), .retExec(retExec),
      .cpuRegsIn(cpuRegsIn), .regsOut(regsOut), .regLoad(regLoad),
      .memReq(memReq), .memRdData(memRdData), .seqBusy(seqBusy)
   );
   sys_partner i_far
   (
      .clk(clk), .memReq(memReq), .memRdData(memRdData),
      .resetPinOe(resetPinOe), .resetPinOut(resetPinOut),
      .extLow(cause[0]), .resetPinIn(resetPinIn)
   );
   // ==========================================================
   // Clock, timeout and helpers.
   always #50 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         fail_count++;
         test_done();
      end
   end
   function logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task check(input string nm, input logic [63:0] s, input logic [63:0] e);
      checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task test_done();
      if (fail_count == 0 && checks > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One APB transfer; read data and error taken at the ready edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Follows one reset sequence from a negedge inside the drive phase.
   task rstSeq(input logic [7:0] stat);
      regQ.push_back('{16'h1234, 16'h00FF, 8'h00, 8'h00, 8'h08});
      mskQ.push_back('{16'hFFFF, 16'hFFFF, 8'h00, 8'h00, 8'h08});
      while (resetPinOe !== 1'b1) @(negedge clk);
      n = 0;
      while (resetPinOe === 1'b1)
      begin
         n++;
         @(negedge clk);
      end
      check("driveLen", n, 34);
      check("resetOuts", {periphDisable, ioForceInput, clkGenSelfClock},
         3'b111);
      n = 0;
      while (inReset === 1'b1)
      begin
         n++;
         @(negedge clk);
      end
      check("waitLen", n, 38);
      while (seqBusy === 1'b1) @(negedge clk);
      apb(0, 8'h00, 0);
      check("status", rdat, stat);
      apb(0, 8'h04, 0);
      check("options", rdat, 8'hC0);
   endtask
   // Services the watchdog, then measures cycles to its reset.
   task wdogTrip(input int lo, input int hi);
      seed = xs(seed);
      apb(1, 8'h00, seed);
      n = 0;
      while (inReset !== 1'b1)
      begin
         n++;
         @(negedge clk);
      end
      check("period", n >= lo && n <= hi, 1);
      rstSeq(8'h20);
   endtask
   // ==========================================================
   // Watcher: each stack write and register load against its note.
   always @(posedge clk)
   begin
      if (!srst && memReq.wr)
      begin
         check("stackWr", memReq, wrQ.pop_front());
      end
      if (!srst && regLoad)
      begin
         check("load", regsOut & mskQ[0],
            regQ.pop_front() & mskQ[0]);
         void'(mskQ.pop_front());
         cpuRegsIn <= regsOut;
      end
   end
   // ==========================================================
   // Main sequence.
   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 0;
      @(negedge clk);
      rstSeq(8'h80);
      apb(0, 8'h10, 0);
      check("unmapped", {err, rdat}, 33'h1_0000_0000);
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk);
         cause <= 5'h10 >> i;
         @(posedge clk);
         cause <= 0;
         @(negedge clk);
         rstSeq(statTab[i]);
      end
      repeat (5)
      begin
         seed = xs(seed);
         apb(1, 8'h00, seed);
         repeat (40) @(posedge clk);
      end
      apb(0, 8'h00, 0);
      check("srsKept", {inReset, rdat}, 8'h40);
      bdmActive <= 1;
      repeat (150) @(posedge clk);
      check("frozen", inReset, 0);
      bdmActive <= 0;
      wdogTrip(60, 68);
      // The short period starts at once, so service first.
      seed = xs(seed);
      apb(1, 8'h00, seed);
      apb(1, 8'h04, 8'h80);
      apb(1, 8'h04, 8'h00);
      apb(0, 8'h04, 0);
      check("writeOnce", rdat, 8'h80);
      wdogTrip(12, 20);
      apb(1, 8'h04, 8'h00);
      repeat (100) @(posedge clk);
      check("disabled", inReset, 0);
      seed = xs(seed);
      bits = seed[7:0] | 8'h03;
      for (int i = 0; i < 8; i++) if (bits[i]) top = i;
      sv = '{seed[31:16], 16'h00F0, seed[15:8], seed[23:16], 8'h01};
      cpuRegsIn <= sv;
      instrDone <= 1;
      irqEvent <= bits;
      @(posedge clk);
      irqEvent <= 0;
      apb(0, 8'h08, 0);
      check("flags", {seqBusy, rdat}, bits);
      instrDone <= 0;
      apb(1, 8'h0C, 8'hFF);
      repeat (10) @(posedge clk);
      check("boundary", seqBusy, 0);
      wrQ = '{'{8'hF0, sv.pc[7:0], 1'b0, 1'b1}, '{8'hEF, sv.pc[15:8], 1'b0,
         1'b1}, '{8'hEE, sv.x, 1'b0, 1'b1}, '{8'hED, sv.a, 1'b0, 1'b1},
         '{8'hEC, sv.cond, 1'b0, 1'b1}};
      regQ.push_back('{{8'h80, top}, 16'h00EB, 8'h00, 8'h00, 8'h08});
      mskQ.push_back('{16'hFFFF, 16'hFFFF, 8'h00, 8'h00, 8'h08});
      // entry order, saved pc and priority
      instrDone <= 1;
      @(negedge clk);
      while (seqBusy !== 1'b1) @(negedge clk);
      while (seqBusy === 1'b1) @(negedge clk);
      apb(1, 8'h08, bits);
      regQ.push_back(sv);
      mskQ.push_back('1);
      retExec <= 1;
      @(posedge clk);
      retExec <= 0;
      @(negedge clk);
      while (seqBusy === 1'b1) @(negedge clk);
      check("leftover", wrQ.size() + regQ.size(), 0);
      test_done();
   end
endmodule
